//--- common/sbd_map.svh
// constants for the shared bus address/data demux
// assumes a 16-bit shared bus, one clock, host strobes sampled synchronously
`ifndef SBD_MAP_SVH
`define SBD_MAP_SVH
`define SBD_BUS_W      16
`define SBD_ADDR_W     11
`define SBD_LANE_LSB   12
`define SBD_LANE_MSB   15
`define SBD_IGN_BIT    11
`define SBD_A16_MSB    10
`define SBD_A16_LSB    2
`define SBD_A8_HI_MSB  2
`define SBD_BYTE_W     8
`endif

//--- common/sbd_pkg.sv
// types for the shared bus address/data demux
// assumes sbd_map.svh supplies the constants
`include "sbd_map.svh"
package sbd_pkg;
  typedef logic [`SBD_BUS_W-1:0]  sbd_word_t;
  typedef logic [`SBD_ADDR_W-1:0] sbd_addr_t;
  typedef logic [3:0]             sbd_lane_t;
  typedef enum logic {SBD_BUS16, SBD_BUS8} sbd_mode_t;
  typedef enum logic [1:0] {SBD_IDLE, SBD_DRIVE, SBD_WAIT} sbd_host_st_t;
endpackage

//--- common/sbd_if.sv
// shared bus between host and device, with per-side enables
// assumes the bench resolves the wire from the two enables
`timescale 1ns/1ns
interface sbd_if;
  import sbd_pkg::*;
  logic      sel;
  logic      wr_n;
  logic      rd_n;
  sbd_word_t host_out;
  sbd_word_t host_oe;
  sbd_word_t dev_out;
  sbd_word_t dev_oe;
  sbd_word_t bus_in;
  modport device (input sel, input wr_n, input rd_n, input bus_in,
                  output dev_out, output dev_oe);
  modport host (output sel, output wr_n, output rd_n, output host_out,
                output host_oe, input bus_in);
endinterface

//--- src/sbd_device.sv
// device end: decodes address and lane enables, moves data
// assumes strobes are synchronous to sys_clk and one cycle wide or longer
`timescale 1ns/1ns
`include "sbd_map.svh"
module sbd_device
  import sbd_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst,
  input  wire sbd_mode_t mode,
  sbd_if.device          bus,
  output sbd_addr_t      addr_q,
  output sbd_lane_t      lane_q,
  output logic           addr_vld_q,
  output sbd_word_t      wr_data_q,
  output logic           wr_vld_q,
  output logic           rd_req_q,
  input  wire sbd_word_t rd_data
);
  logic      wr_n_q, rd_n_q, second_q, second_d;
  sbd_addr_t addr_d;
  sbd_lane_t lane_d;
  logic      addr_vld_d, wr_vld_d, rd_req_d;
  sbd_word_t wr_data_d, out_d, oe_d, out_q, oe_q, used;
  logic      wr_edge, rd_act;

  assign bus.dev_out = out_q;
  assign bus.dev_oe  = oe_q;

  always_comb
  begin
    wr_edge    = wr_n_q && !bus.wr_n;
    rd_act     = !bus.rd_n;
    used       = (mode == SBD_BUS16) ? 16'hffff : 16'h00ff;
    addr_d     = addr_q;
    lane_d     = lane_q;
    second_d   = second_q;
    addr_vld_d = 1'b0;
    wr_vld_d   = 1'b0;
    wr_data_d  = wr_data_q;
    rd_req_d   = rd_act && rd_n_q && !bus.sel;
    if (wr_edge && bus.sel)
    begin
      if (mode == SBD_BUS16)
      begin
        lane_d = bus.bus_in[`SBD_LANE_MSB:`SBD_LANE_LSB];
        addr_d = {bus.bus_in[`SBD_A16_MSB:`SBD_A16_LSB], 2'b00};
        addr_vld_d = 1'b1;
      end
      else if (!second_q)
      begin
        addr_d[`SBD_BYTE_W-1:0] = bus.bus_in[`SBD_BYTE_W-1:0];
        second_d = 1'b1;
      end
      else
      begin
        addr_d[`SBD_ADDR_W-1:`SBD_BYTE_W] = bus.bus_in[`SBD_A8_HI_MSB:0];
        lane_d     = 4'hf;
        second_d   = 1'b0;
        addr_vld_d = 1'b1;
      end
    end
    else if (wr_edge)
    begin
      // data bits in use; upper byte low from host
      wr_data_d = bus.bus_in & used;
      wr_vld_d  = 1'b1;
    end
    oe_d  = (rd_act && !bus.sel) ? used : 16'h0000;
    out_d = rd_data & used;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      second_q <= 1'b0;
      addr_q <= '0;
      lane_q <= '0;
      addr_vld_q <= 1'b0;
      wr_vld_q <= 1'b0;
      wr_data_q <= '0;
      rd_req_q <= 1'b0;
      out_q <= '0;
      oe_q <= '0;
    end
    else
    begin
      wr_n_q <= bus.wr_n;
      rd_n_q <= bus.rd_n;
      second_q <= second_d;
      addr_q <= addr_d;
      lane_q <= lane_d;
      addr_vld_q <= addr_vld_d;
      wr_vld_q <= wr_vld_d;
      wr_data_q <= wr_data_d;
      rd_req_q <= rd_req_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end
endmodule // sbd_device

//--- src/sbd_host.sv
// host end: runs one address or data access per request
// assumes the device answers a read within the two low strobe cycles
`timescale 1ns/1ns
`include "sbd_map.svh"
module sbd_host
  import sbd_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst,
  input  wire sbd_mode_t mode,
  input  wire logic      req,
  input  wire logic      req_sel,
  input  wire logic      req_rd,
  input  wire sbd_word_t req_word,
  output logic           busy_q,
  output logic           done_q,
  output sbd_word_t      rd_word_q,
  sbd_if.host            bus
);
  sbd_host_st_t st_q, st_d;
  logic      sel_q, sel_d, wr_n_q, wr_n_d, rd_n_q, rd_n_d, rd_q, rd_d;
  logic      done_d, hold_q, hold_d, busy_d;
  sbd_word_t out_q, out_d, oe_q, oe_d, rdw_d, keep;

  assign bus.sel      = sel_q;
  assign bus.wr_n     = wr_n_q;
  assign bus.rd_n     = rd_n_q;
  assign bus.host_out = out_q;
  assign bus.host_oe  = oe_q;

  always_comb
  begin
    keep   = (mode == SBD_BUS16) ? 16'hffff : 16'h00ff;
    st_d   = st_q;
    sel_d  = sel_q;
    wr_n_d = 1'b1;
    rd_n_d = 1'b1;
    rd_d   = rd_q;
    out_d  = out_q;
    oe_d   = 16'h0000;
    done_d = 1'b0;
    rdw_d  = rd_word_q;
    hold_d = 1'b0;
    unique case (st_q)
      SBD_IDLE:
        if (req)
        begin
          sel_d = req_sel;
          rd_d  = req_rd && !req_sel;
          // upper byte forced low here in 8-bit, not left to caller
          out_d = req_word & keep;
          st_d  = SBD_DRIVE;
        end
      SBD_DRIVE:
      begin
        wr_n_d = rd_q;
        rd_n_d = !rd_q;
        oe_d   = rd_q ? 16'h0000 : 16'hffff;
        st_d   = SBD_WAIT;
      end
      SBD_WAIT:
      begin
        // device oe lags the strobe by one cycle, so hold read one more
        if (rd_q && !hold_q)
        begin
          hold_d = 1'b1;
          rd_n_d = 1'b0;
        end
        else
        begin
          if (rd_q)
            rdw_d = bus.bus_in & keep;
          done_d = 1'b1;
          st_d   = SBD_IDLE;
        end
      end
      default:
        st_d = SBD_IDLE;
    endcase
    if (st_q == SBD_WAIT && !rd_q)
      oe_d = 16'hffff;
    busy_d = (st_d != SBD_IDLE);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_q <= SBD_IDLE;
      sel_q <= 1'b0;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      rd_q <= 1'b0;
      out_q <= '0;
      oe_q <= '0;
      done_q <= 1'b0;
      rd_word_q <= '0;
      hold_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      sel_q <= sel_d;
      wr_n_q <= wr_n_d;
      rd_n_q <= rd_n_d;
      rd_q <= rd_d;
      out_q <= out_d;
      oe_q <= oe_d;
      done_q <= done_d;
      rd_word_q <= rdw_d;
      hold_q <= hold_d;
      busy_q <= busy_d;
    end
  end
endmodule // sbd_host

//--- tb/sbd_assertions.sv
// wire-level checks on the host/device shared bus
// assumes sys_clk and synchronous active-high rst, signals from sbd_if
`timescale 1ns/1ns
module sbd_assertions
  import sbd_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      rst,
  input wire logic      sel,
  input wire logic      wr_n,
  input wire logic      rd_n,
  input wire sbd_word_t host_oe,
  input wire sbd_word_t dev_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // oe lags the strobe, so allow two cycles of tail
  a_oe_only_read: assert property ((|dev_oe) |->
    (!rd_n || !$past(rd_n) || !$past(rd_n, 2))) else $error("dev oe outside read");
  a_no_bus_fight: assert property (!(|(dev_oe & host_oe)))
    else $error("both ends drive");
  a_oe_not_write: assert property (!wr_n |-> dev_oe == 16'h0000)
    else $error("dev oe during write");
  a_read_drives: assert property ($fell(rd_n) && !sel |->
    ##[1:2] dev_oe[7:0] == 8'hff) else $error("read not driven");
  a_oe_width: assert property ((|dev_oe) |->
    dev_oe inside {16'h00ff, 16'hffff}) else $error("bad oe width");
  a_strobe_excl: assert property (!(!wr_n && !rd_n))
    else $error("both strobes low");
  a_wr_pulse: assert property ($fell(wr_n) |=> wr_n)
    else $error("write strobe too long");
  a_host_drives: assert property (!wr_n |-> host_oe != 16'h0000)
    else $error("write not driven");
endmodule // sbd_assertions

//--- tb/shared_bus_addr_data_demux_tb.sv
// bench: host and device ends joined, user sides driven and checked
// assumes design files and sbd_if compiled first
`timescale 1ns/1ns
module shared_bus_addr_data_demux_tb
  import sbd_pkg::*;
;
  logic      sys_clk = 1'b0;
  logic      rst = 1'b1;
  logic      req = 1'b0;
  logic      req_sel = 1'b0;
  logic      req_rd = 1'b0;
  sbd_mode_t mode = SBD_BUS16;
  sbd_word_t req_word = 16'h0000;
  sbd_word_t rd_data = 16'h1234;
  sbd_word_t wr_data_q;
  sbd_word_t rd_word_q;
  sbd_addr_t addr_q;
  sbd_lane_t lane_q;
  logic      addr_vld_q;
  logic      done_q;
  int        n_mismatch = 0;
  int        cmp_count = 0;
  int        n_vld = 0;
  sbd_if bif ();
  // wire is the or of whatever each end enables
  assign bif.bus_in = (bif.host_out & bif.host_oe)
                    | (bif.dev_out & bif.dev_oe);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (addr_vld_q === 1'b1) n_vld++;
  end
  sbd_device u_sbd_device (.sys_clk(sys_clk), .rst(rst), .mode(mode),
    .bus(bif), .addr_q(addr_q), .lane_q(lane_q), .addr_vld_q(addr_vld_q),
    .wr_data_q(wr_data_q), .wr_vld_q(), .rd_req_q(), .rd_data(rd_data));
  sbd_host u_sbd_host (.sys_clk(sys_clk), .rst(rst), .mode(mode),
    .req(req), .req_sel(req_sel), .req_rd(req_rd), .req_word(req_word),
    .busy_q(), .done_q(done_q), .rd_word_q(rd_word_q), .bus(bif));
  sbd_assertions u_sbd_assertions (.sys_clk(sys_clk), .rst(rst),
    .sel(bif.sel), .wr_n(bif.wr_n), .rd_n(bif.rd_n),
    .host_oe(bif.host_oe), .dev_oe(bif.dev_oe));

  task automatic stop_test;
  begin
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  task automatic chk(input sbd_word_t got, input sbd_word_t exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  // one host access, bounded wait on done
  task automatic acc(input logic s, input logic r, input sbd_word_t w);
    int i;
  begin
    @(posedge sys_clk);
    #2;
    req = 1'b1;
    req_sel = s;
    req_rd = r;
    req_word = w;
    @(posedge sys_clk);
    #2;
    req = 1'b0;
    for (i = 0; i < 20 && done_q !== 1'b1; i++)
    begin
      @(posedge sys_clk);
      #2;
    end
    if (i == 20)
    begin
      n_mismatch++;
      stop_test;
    end
    repeat (2) @(posedge sys_clk);
    #2;
  end
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    acc(1'b1, 1'b0, 16'h5fff);
    chk({5'h00, addr_q}, 16'h07fc);
    chk({12'h000, lane_q}, 16'h0005);
    acc(1'b0, 1'b0, 16'ha5c3);
    chk(wr_data_q, 16'ha5c3);
    acc(1'b0, 1'b1, 16'h0000);
    chk(rd_word_q, 16'h1234);
    mode = SBD_BUS8;
    acc(1'b1, 1'b0, 16'h00a5);
    chk(n_vld[15:0], 16'h0001);
    acc(1'b1, 1'b0, 16'h00fd);
    chk({5'h00, addr_q}, 16'h05a5);
    chk(n_vld[15:0], 16'h0002);
    // upper byte offered dirty; host must clear it in 8-bit mode
    acc(1'b0, 1'b0, 16'hff3c);
    chk(wr_data_q, 16'h003c);
    stop_test;
  end
endmodule // shared_bus_addr_data_demux_tb
